// ==== core/dds_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module dds_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // DEPTH must be a power of two; pointers wrap naturally
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push     = in_valid & in_ready;
  // Output stage is a register so the consumer sees flop outputs
  assign pop      = (cnt_q != '0) & (~out_valid | out_ready);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop) begin
        out_data  <= mem_q[rd_q];
        out_valid <= 1'b1;
        rd_q      <= rd_q + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// ==== core/dds_map.svh ====
// Contract
// - Byte offset add matters only while the one-shot alternate add is enabled.
// - Byte offset add: alternate top byte plus primary top byte, primary low 24 bits.
// - Without byte offset add the full 32-bit alternate increment is accumulated.
// - Output format bit 1 gives offset binary, 0 gives two's complement.
// - Both codings differ only in the sample MSB.
// - Dither scales to programmed DAC width; narrow DACs use the top sample bits.
// - Width code 111 bypasses the dither circuit completely.
// - Static control: bit7 strobe invert, bit5 byte add, bit3 format, bits2..0 width.
// - One-shot mode adds the alternate increment once per update strobe, then primary.
// - External select disabled means increment_select is ignored and primary is used.
// - Any write to the clear arm register zeroes the accumulator at next update strobe.
// - Any write to the soft activate register activates pending settings like a strobe.
// - Soft activation takes effect within four system clock periods.
// - increment_select 0 picks primary, 1 picks alternate increment.
// - increment_select is captured on a select_strobe rising edge and held until the next one.
// - select_strobe is synchronised into the system clock domain before use.
// - 32-bit accumulator adds the selected increment every clock without a stall, wrapping around.
// - Lookup phase is offset by code times 45 degrees; stored phase stays untouched.
// - phase_offset_code is captured on a synchronised offset_strobe edge.
// - Each 12-bit sample comes from the top 16 bits of the offset phase.
`ifndef DDS_MAP_SVH
`define DDS_MAP_SVH

`define DDS_ADDR_PRI_B0   5'h00
`define DDS_ADDR_PRI_B3   5'h03
`define DDS_ADDR_ALT_B0   5'h04
`define DDS_ADDR_ALT_B3   5'h07
`define DDS_ADDR_SYNC     5'h08
`define DDS_ADDR_STATIC   5'h0a
`define DDS_ADDR_CLR_ARM  5'h0c
`define DDS_ADDR_SOFT_ACT 5'h0d

`define DDS_SYNC_ONESHOT  3
`define DDS_SYNC_EXTSEL   2
`define DDS_SYNC_EXTPHASE 1
`define DDS_STAT_STB_INV  7
`define DDS_STAT_BYTE_ADD 5
`define DDS_STAT_FORMAT   3

`define DDS_SYNC_RST      8'h00
`define DDS_STATIC_RST    8'h07
`define DDS_DITHER_OFF    3'h7
`define DDS_DITHER_MAXC   3'h6
`define DDS_LFSR_SEED     16'h0001

`define DDS_SAMPLE_W      12
`define DDS_FIFO_DEPTH    8

`endif

// ==== core/dds_phase_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dds_map.svh"
module dds_phase_datapath
  import dds_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire dds_bus_s   bus_in,
  input  wire logic       update_strobe,
  input  wire logic       increment_select,
  input  wire logic       select_strobe,
  input  wire logic [2:0] phase_offset_code,
  input  wire logic       offset_strobe,
  input  wire logic       sample_ready,
  output logic [11:0]     sample_data,
  output logic            sample_valid,
  output logic            dac_strobe_invert
);

  // Quarter-wave sine, 32 segments, amplitude 2047
  localparam logic [10:0] SINE_LUT [0:32] = '{
    11'h000, 11'h064, 11'h0c9, 11'h12c, 11'h18f, 11'h1f1, 11'h252, 11'h2b2,
    11'h30f, 11'h36b, 11'h3c5, 11'h41c, 11'h471, 11'h4c3, 11'h513, 11'h55f,
    11'h5a7, 11'h5ed, 11'h62e, 11'h66c, 11'h6a6, 11'h6dc, 11'h70d, 11'h73a,
    11'h763, 11'h787, 11'h7a7, 11'h7c2, 11'h7d8, 11'h7e9, 11'h7f5, 11'h7fd,
    11'h7ff
  };

  localparam dds_state_s STATE_RST = '{
    wr_n_prev  : 1'b1,
    upd_prev   : 1'b0,
    sel_sync   : 3'h0,
    off_sync   : 3'h0,
    pend_pri   : 32'h0000_0000,
    pend_alt   : 32'h0000_0000,
    pend_sync  : `DDS_SYNC_RST,
    act_pri    : 32'h0000_0000,
    act_alt    : 32'h0000_0000,
    act_sync   : `DDS_SYNC_RST,
    static_ctl : `DDS_STATIC_RST,
    clear_arm  : 1'b0,
    soft_pend  : 1'b0,
    ext_sel    : 1'b0,
    src        : DDS_SRC_PRIMARY,
    acc        : 32'h0000_0000,
    off_code   : 3'h0,
    phase16    : 16'h0000,
    sample     : 12'h000,
    lfsr       : `DDS_LFSR_SEED,
    out_word   : 12'h000,
    out_vld    : 1'b0
  };

  dds_state_s  s_q;
  dds_state_s  s_d;

  logic        fifo_in_ready;
  logic        wr_take;
  logic        hop_rise;
  logic        upd_evt;
  logic        sel_rise;
  logic        off_rise;
  logic        stall;
  logic        one_shot_on;
  logic        byte_add_on;
  logic [31:0] alt_inc;
  logic [31:0] inc;
  logic [13:0] quarter_pos;
  logic [4:0]  seg;
  logic [10:0] seg_lo;
  logic [10:0] seg_hi;
  logic [19:0] slope_prod;
  logic [10:0] amp;
  logic [11:0] smp;
  logic [2:0]  width_code;
  logic [2:0]  drop;
  logic [11:0] noise_mask;
  logic [12:0] dith_sum;
  logic [11:0] dith_val;
  logic [11:0] coded;

  always_comb begin
    s_d = s_q;

    // Bus write taken on the falling edge of the write strobe
    wr_take       = ~bus_in.cs_n & ~bus_in.wr_n & s_q.wr_n_prev;
    s_d.wr_n_prev = bus_in.wr_n;

    hop_rise     = update_strobe & ~s_q.upd_prev;
    s_d.upd_prev = update_strobe;

    // Stage 0 of each synchroniser feeds only stage 1
    s_d.sel_sync = {s_q.sel_sync[1:0], select_strobe};
    s_d.off_sync = {s_q.off_sync[1:0], offset_strobe};
    sel_rise     = s_q.sel_sync[1] & ~s_q.sel_sync[2];
    off_rise     = s_q.off_sync[1] & ~s_q.off_sync[2];

    stall = s_q.out_vld & ~fifo_in_ready;

    // Register writes; pending copies wait for activation
    s_d.soft_pend = 1'b0;
    if (wr_take) begin
      if (bus_in.addr <= `DDS_ADDR_PRI_B3) begin
        s_d.pend_pri[bus_in.addr[1:0]*8 +: 8] = bus_in.data;
      end else if (bus_in.addr <= `DDS_ADDR_ALT_B3) begin
        s_d.pend_alt[bus_in.addr[1:0]*8 +: 8] = bus_in.data;
      end else begin
        case (bus_in.addr)
          `DDS_ADDR_SYNC:     s_d.pend_sync = bus_in.data;
          `DDS_ADDR_STATIC:   s_d.static_ctl = bus_in.data;
          `DDS_ADDR_SOFT_ACT: s_d.soft_pend = 1'b1;
          default:            s_d.soft_pend = 1'b0;
        endcase
      end
    end

    // Activation by strobe edge or one cycle after a soft write
    upd_evt = hop_rise | s_q.soft_pend;
    if (upd_evt) begin
      s_d.act_pri  = s_q.pend_pri;
      s_d.act_alt  = s_q.pend_alt;
      s_d.act_sync = s_q.pend_sync;
    end

    // Clear fires on the strobe edge; a new arm in the same cycle wins
    if (hop_rise && s_q.clear_arm) begin
      s_d.clear_arm = 1'b0;
    end
    if (wr_take && bus_in.addr == `DDS_ADDR_CLR_ARM) begin
      s_d.clear_arm = 1'b1;
    end

    if (sel_rise && s_d.act_sync[`DDS_SYNC_EXTSEL]) begin
      s_d.ext_sel = increment_select;
    end

    if (off_rise && s_d.act_sync[`DDS_SYNC_EXTPHASE]) begin
      s_d.off_code = phase_offset_code;
    end

    // Increment for this cycle
    one_shot_on = s_q.act_sync[`DDS_SYNC_ONESHOT];
    byte_add_on = one_shot_on & s_q.static_ctl[`DDS_STAT_BYTE_ADD];
    if (byte_add_on) begin
      alt_inc = {s_q.act_alt[31:24] + s_q.act_pri[31:24], s_q.act_pri[23:0]};
    end else begin
      alt_inc = s_q.act_alt;
    end
    case (s_q.src)
      DDS_SRC_PRIMARY:  inc = s_q.act_pri;
      DDS_SRC_ALT_ONCE: inc = alt_inc;
      DDS_SRC_ALT_HOLD: inc = alt_inc;
      default:          inc = s_q.act_pri;
    endcase

    // Next source; a held one-shot survives a stall
    if (upd_evt && s_d.act_sync[`DDS_SYNC_ONESHOT]) begin
      s_d.src = DDS_SRC_ALT_ONCE;
    end else if (s_q.src == DDS_SRC_ALT_ONCE && stall) begin
      s_d.src = DDS_SRC_ALT_ONCE;
    end else if (s_d.act_sync[`DDS_SYNC_EXTSEL] && s_d.ext_sel) begin
      s_d.src = DDS_SRC_ALT_HOLD;
    end else begin
      s_d.src = DDS_SRC_PRIMARY;
    end

    // Accumulator holds only while the sample FIFO refuses data
    if (hop_rise && s_q.clear_arm) begin
      s_d.acc = 32'h0000_0000;
    end else if (!stall) begin
      s_d.acc = s_q.acc + inc;
    end

    // Sine lookup: mirror within quadrant, interpolate one segment
    quarter_pos = s_q.phase16[14] ? ~s_q.phase16[13:0] : s_q.phase16[13:0];
    seg         = quarter_pos[13:9];
    seg_lo      = SINE_LUT[seg];
    seg_hi      = SINE_LUT[6'({1'b0, seg} + 6'h01)];
    slope_prod  = 20'(seg_hi - seg_lo) * 20'(quarter_pos[8:0]);
    amp         = seg_lo + slope_prod[19:9];
    smp         = s_q.phase16[15] ? 12'(-{1'b0, amp}) : {1'b0, amp};

    // Dither: add noise below the kept LSB, then truncate
    width_code = s_q.static_ctl[2:0];
    drop       = (width_code > `DDS_DITHER_MAXC) ? 3'h0 : (`DDS_DITHER_MAXC - width_code);
    noise_mask = 12'((13'h0001 << drop) - 13'h0001);
    dith_sum   = {s_q.sample[11], s_q.sample} + {1'b0, s_q.lfsr[11:0] & noise_mask};
    if (width_code == `DDS_DITHER_OFF) begin
      dith_val = s_q.sample;
    end else if (!dith_sum[12] && dith_sum[11]) begin
      // Positive overflow would wrap to the most negative code
      dith_val = 12'h7ff & ~noise_mask;
    end else begin
      dith_val = dith_sum[11:0] & ~noise_mask;
    end

    if (s_q.static_ctl[`DDS_STAT_FORMAT]) begin
      coded = {~dith_val[11], dith_val[10:0]};
    end else begin
      coded = dith_val;
    end

    // Pipeline advances together so a refused word is offered again
    if (!stall) begin
      s_d.phase16  = s_q.acc[31:16] + {s_q.off_code, 13'h0000};
      s_d.sample   = smp;
      s_d.lfsr     = {s_q.lfsr[14:0],
                      s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};
      s_d.out_word = coded;
      s_d.out_vld  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign dac_strobe_invert = s_q.static_ctl[`DDS_STAT_STB_INV];

  dds_fifo #(
    .WIDTH (`DDS_SAMPLE_W),
    .DEPTH (`DDS_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (s_q.out_vld),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.out_word),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );

endmodule
`default_nettype wire

// ==== core/dds_pkg.sv ====
`include "dds_map.svh"
package dds_pkg;

  typedef enum logic [2:0] {
    DDS_SRC_PRIMARY  = 3'b001,
    DDS_SRC_ALT_ONCE = 3'b010,
    DDS_SRC_ALT_HOLD = 3'b100
  } dds_src_e;

  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic [4:0] addr;
    logic [7:0] data;
  } dds_bus_s;

  typedef struct packed {
    logic        wr_n_prev;
    logic        upd_prev;
    logic [2:0]  sel_sync;
    logic [2:0]  off_sync;
    logic [31:0] pend_pri;
    logic [31:0] pend_alt;
    logic [7:0]  pend_sync;
    logic [31:0] act_pri;
    logic [31:0] act_alt;
    logic [7:0]  act_sync;
    logic [7:0]  static_ctl;
    logic        clear_arm;
    logic        soft_pend;
    logic        ext_sel;
    dds_src_e    src;
    logic [31:0] acc;
    logic [2:0]  off_code;
    logic [15:0] phase16;
    logic [11:0] sample;
    logic [15:0] lfsr;
    logic [11:0] out_word;
    logic        out_vld;
  } dds_state_s;

endpackage

// ==== testbench/dds_dac_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module dds_dac_sink (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic stall_en,
  output logic      sample_ready
);
  logic [3:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    cnt_q <= rst ? 4'h0 : cnt_q + 4'h1;
  end
  // Refusing 12 of 16 cycles outlasts the 8-word FIFO
  assign sample_ready = !stall_en || cnt_q >= 4'hc;
endmodule
`default_nettype wire

// ==== testbench/dds_phase_datapath_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dds_phase_datapath_chk
  import dds_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire dds_bus_s    bus_in,
  input wire logic        sample_ready,
  input wire logic [11:0] sample_data,
  input wire logic        sample_valid,
  input wire logic        dac_strobe_invert
);
  logic       wr_prev_q;
  logic [7:0] st_q;
  logic [4:0] qt_q;
  logic       stw;
  logic       settled;

  assign stw = !bus_in.cs_n && !bus_in.wr_n && wr_prev_q && bus_in.addr == 5'h0a;
  // Pipeline plus FIFO still hold words coded under the old setting
  assign settled = qt_q == 5'h10 && sample_valid;

  always_ff @(posedge sys_clk) begin
    wr_prev_q <= rst | bus_in.wr_n;
    if (rst || stw) begin
      qt_q <= 5'h00;
    end else if (sample_valid && sample_ready && qt_q != 5'h10) begin
      qt_q <= qt_q + 5'h01;
    end
    if (rst) begin
      st_q <= 8'h07;
    end else if (stw) begin
      st_q <= bus_in.data;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (
    disable iff (1'b0) rst |=> !sample_valid && !dac_strobe_invert)
    else $error("outputs active right after reset");
  a_hold_stall: assert property (
    sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
    else $error("sample dropped or changed while refused");
  a_inv_write: assert property (
    stw |=> dac_strobe_invert == $past(bus_in.data[7]))
    else $error("strobe invert does not follow control write");
  a_inv_only: assert property (
    $changed(dac_strobe_invert) |-> $past(stw))
    else $error("strobe invert changed without control write");
  a_width_trunc: assert property (
    settled && st_q[2:0] != 3'h7 |-> (sample_data & (12'h03f >> st_q[2:0])) == 12'h000)
    else $error("bits below programmed width not zero");
  a_flow_start: assert property (
    $fell(rst) |-> ##[1:16] sample_valid)
    else $error("no sample after reset");
  a_flow_steady: assert property (
    sample_valid && sample_ready |=> sample_valid)
    else $error("sample stream has a gap");
  a_ob_nonzero: assert property (
    settled && st_q[3] && st_q[2:0] == 3'h7 |-> sample_data != 12'h000)
    else $error("offset binary sample below range");
  a_tc_no_min: assert property (
    settled && !st_q[3] && st_q[2:0] == 3'h7 |-> sample_data != 12'h800)
    else $error("two's complement sample below range");

  c_stall: cover property (sample_valid && !sample_ready);
  c_static: cover property (stw);
  c_narrow: cover property (settled && st_q[2:0] == 3'h0);
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dds_map.svh"
`define TB_CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module tb_top
  import dds_pkg::*;
;
  logic        sys_clk, rst, upd, isel, sstb, ostb, ready, stall, svalid, sinv;
  dds_bus_s    bus;
  logic [2:0]  ocode;
  logic [11:0] sdata;
  logic [11:0] s [16];
  int          fails, comparisons;

  dds_phase_datapath u_dut (.sys_clk(sys_clk), .rst(rst), .bus_in(bus), .update_strobe(upd),
    .increment_select(isel), .select_strobe(sstb), .phase_offset_code(ocode),
    .offset_strobe(ostb), .sample_ready(ready), .sample_data(sdata), .sample_valid(svalid),
    .dac_strobe_invert(sinv));
  dds_dac_sink u_sink (.sys_clk(sys_clk), .rst(rst), .stall_en(stall), .sample_ready(ready));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{cs_n: 1'b0, wr_n: 1'b0, addr: a, data: d};
    @(posedge sys_clk);
    bus.wr_n <= 1'b1;
  endtask

  task automatic wr32(input logic [4:0] a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) wr(a + 5'(k), v[k*8 +: 8]);
  endtask

  task automatic hop();
    @(posedge sys_clk);
    upd <= 1'b1;
    @(posedge sys_clk);
    upd <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Held over several clocks so the synchroniser sees it
  task automatic pls(input bit off);
    @(posedge sys_clk);
    if (off) ostb <= 1'b1;
    else sstb <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ostb <= 1'b0;
    sstb <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic get(output logic [11:0] v);
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      #1;
      if (svalid === 1'b1 && ready === 1'b1) break;
    end
    if (i == 100) begin
      fails++;
      summarize();
    end
    v = sdata;
  endtask

  task automatic grab(input int n);
    repeat (24) get(s[0]);
    for (int k = 0; k < n; k++) get(s[k]);
  endtask

  function automatic logic pk4();
    pk4 = 1'b0;
    for (int k = 0; k < 4; k++) pk4 |= s[k][11:2] == 10'h1ff;
  endfunction

  task automatic clr();
    wr(`DDS_ADDR_SYNC, 8'h00);
    wr(`DDS_ADDR_CLR_ARM, 8'h5a);
    hop();
  endtask

  task automatic t_static();
    `TB_CHK(sinv, 1'b0)
    wr(`DDS_ADDR_STATIC, 8'h8f);
    grab(1);
    `TB_CHK(sinv, 1'b1)
    `TB_CHK(s[0], 12'h800)
    wr(`DDS_ADDR_STATIC, 8'h07);
    grab(1);
    `TB_CHK(s[0], 12'h000)
  endtask

  task automatic t_phase();
    wr(`DDS_ADDR_SYNC, 8'h02);
    hop();
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      ocode <= 3'(k * 2);
      pls(1'b1);
      grab(1);
      `TB_CHK(s[0][11:2], k == 1 ? 10'h1ff : k == 3 ? 10'h200 : 10'h000)
    end
    @(posedge sys_clk);
    ocode <= 3'h2;
    grab(1);
    `TB_CHK(s[0][11:2], 10'h200)
    @(posedge sys_clk);
    ocode <= 3'h0;
    pls(1'b1);
    grab(1);
    `TB_CHK(s[0], 12'h000)
  endtask

  task automatic t_oneshot();
    wr32(`DDS_ADDR_ALT_B0, 32'h4000_0000);
    wr(`DDS_ADDR_SYNC, 8'h08);
    hop();
    grab(4);
    `TB_CHK(s[0][11:2], 10'h1ff)
    `TB_CHK(s[3], s[0])
    wr(`DDS_ADDR_SYNC, 8'h00);
    wr(`DDS_ADDR_CLR_ARM, 8'h00);
    grab(1);
    `TB_CHK(s[0][11:2], 10'h1ff)
    hop();
    grab(1);
    `TB_CHK(s[0], 12'h000)
  endtask

  task automatic t_byteadd();
    wr32(`DDS_ADDR_ALT_B0, 32'h00c0_0000);
    wr(`DDS_ADDR_STATIC, 8'h27);
    wr(`DDS_ADDR_SYNC, 8'h08);
    hop();
    grab(1);
    `TB_CHK(s[0], 12'h000)
    wr(`DDS_ADDR_STATIC, 8'h07);
    hop();
    grab(1);
    `TB_CHK(s[0] != 12'h000, 1'b1)
    clr();
  endtask

  task automatic t_select();
    wr32(`DDS_ADDR_ALT_B0, 32'h4000_0000);
    @(posedge sys_clk);
    isel <= 1'b1;
    pls(1'b0);
    grab(4);
    `TB_CHK(pk4(), 1'b0)
    wr(`DDS_ADDR_SYNC, 8'h04);
    hop();
    grab(4);
    `TB_CHK(pk4(), 1'b0)
    pls(1'b0);
    grab(4);
    `TB_CHK(pk4(), 1'b1)
    @(posedge sys_clk);
    isel <= 1'b0;
    pls(1'b0);
    grab(4);
    `TB_CHK(s[3], s[0])
    clr();
  endtask

  task automatic t_soft();
    wr32(`DDS_ADDR_PRI_B0, 32'h4000_0000);
    grab(4);
    `TB_CHK(pk4(), 1'b0)
    wr(`DDS_ADDR_SOFT_ACT, 8'h00);
    stall <= 1'b1;
    grab(16);
    for (int k = 0; k < 12; k++) `TB_CHK(s[k + 4], s[k])
    `TB_CHK(pk4(), 1'b1)
    @(posedge sys_clk);
    stall <= 1'b0;
  endtask

  task automatic t_width();
    logic [11:0] m;
    wr32(`DDS_ADDR_PRI_B0, 32'h0123_4567);
    wr(`DDS_ADDR_SOFT_ACT, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(`DDS_ADDR_STATIC, 8'(c));
      grab(16);
      m = 12'h000;
      for (int k = 0; k < 16; k++) m |= s[k] & (12'h03f >> (c % 7));
      if (c < 7) `TB_CHK(m, 12'h000)
      else `TB_CHK(m != 12'h000, 1'b1)
    end
  endtask

  initial begin
    rst = 1'b1;
    bus = '1;
    {upd, isel, sstb, ostb, stall, ocode} = '0;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_static();
    t_phase();
    t_oneshot();
    t_byteadd();
    t_select();
    t_soft();
    t_width();
    summarize();
  end
endmodule

bind dds_phase_datapath dds_phase_datapath_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .bus_in(bus_in), .sample_ready(sample_ready), .sample_data(sample_data),
  .sample_valid(sample_valid), .dac_strobe_invert(dac_strobe_invert));
`default_nettype wire
